// *** rtl/spindle_io_pkg.sv ***
// Constants and types for the spindle command and status logic
package spindle_io_pkg;
   // APB register byte addresses
   localparam logic [7:0] ADDR_CONFIG    = 8'h00;
   localparam logic [7:0] ADDR_THRESHOLD = 8'h04;
   localparam logic [7:0] ADDR_ALARM     = 8'h08;
   localparam logic [7:0] ADDR_POSITION  = 8'h0C;
   localparam logic [7:0] ADDR_IN_MON    = 8'h10;
   localparam logic [7:0] ADDR_OUT_MON   = 8'h14;
   // Config field positions
   localparam int CFG_FMT_LSB    = 0;
   localparam int CFG_INVERT     = 2;
   localparam int CFG_INT_EN     = 3;
   localparam int CFG_RANGE      = 4;
   localparam int CFG_FAULT_POL  = 5;
   localparam int CFG_INDEX_SRC  = 6;
   localparam logic [6:0] CFG_RESET = 7'h00;
   localparam logic [15:0] THRESHOLD_RESET = 16'h000A;
   // Alarm number limit for clear by input
   localparam logic [7:0] ALARM_CLEARABLE_MAX = 8'h09;
   // Input monitor bit positions
   localparam int IN_ENABLE  = 0;
   localparam int IN_CLEAR   = 1;
   localparam int IN_INHIBIT = 2;
   localparam int IN_DEVCLR  = 3;
   // Output monitor bit positions
   localparam int OUT_FAULT  = 0;
   localparam int OUT_READY  = 1;
   localparam int OUT_ZERO   = 2;
   localparam int OUT_INDEX  = 3;
   // Pulse rate limit
   localparam int MAX_PULSE_KHZ = 1000;
   localparam int CLOCK_KHZ     = 100000;
   localparam int PULSE_PERIOD_CYCLES = CLOCK_KHZ / MAX_PULSE_KHZ;
   typedef enum logic [1:0] {
      FMT_PULSE_DIR,
      FMT_CCW_CW,
      FMT_QUADRATURE,
      FMT_UNUSED
   } pulse_format_type;
endpackage

// *** rtl/spindle_command_io_logic.sv ***
// Command pulse decode, enable and alarm handling, status outputs
`timescale 1ns/10ps
module spindle_command_io_logic
   import spindle_io_pkg::*;
#(
   parameter int POS_WIDTH   = 32,
   parameter int SPEED_WIDTH = 16
)(
   input  wire logic                   clock,             // System clock 100 MHz
   input  wire logic                   sys_rst,           // Async reset, high
   input  wire logic                   psel,              // APB select
   input  wire logic                   penable,           // APB enable
   input  wire logic                   pwrite,            // APB write
   input  wire logic [7:0]             paddr,             // APB byte address
   input  wire logic [31:0]            pwdata,            // APB write data
   output logic                        pready,            // APB ready
   output logic      [31:0]            prdata,            // APB read data
   output logic                        pslverr,           // APB error
   input  wire logic                   command_pulse_in,  // Pulse / CCW / A phase
   input  wire logic                   command_sign_in,   // Direction / CW / B phase
   input  wire logic                   drive_enable_in_n, // Enable, low active pin
   input  wire logic                   alarm_clear_in_n,  // Alarm clear, low active
   input  wire logic                   pulse_inhibit_in_n,// Pulse inhibit, low active
   input  wire logic                   deviation_clear_in_n, // Deviation clear, low
   input  wire logic [SPEED_WIDTH-1:0] measured_speed,    // Motor speed magnitude
   input  wire logic                   alarm_event,       // Fault detected pulse
   input  wire logic [7:0]             alarm_code,        // Number of that fault
   input  wire logic                   motor_index_in,    // Motor encoder Z
   input  wire logic                   aux_index_in,      // Second feedback Z
   output logic                        servo_on,          // Motor energized
   output logic                        analog_unipolar,   // Analog range select
   output logic                        fault_out,         // Fault pin level
   output logic                        drive_ready_out,   // Ready pin level
   output logic                        zero_speed_out,    // Zero speed pin level
   output logic                        index_pulse_out,   // Index pin level
   output logic      [POS_WIDTH-1:0]   position_count     // Accumulated command
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [5:0] sync_a;
   logic [5:0] sync_b;
   logic [5:0] prev_b;
   logic [5:0] pins;
   logic [2:0] warm;

   // Low pin level means asserted for the four control pins; pulse and sign pass uninverted
   assign pins = {command_sign_in, command_pulse_in, ~deviation_clear_in_n,
                  ~pulse_inhibit_in_n, ~alarm_clear_in_n, ~drive_enable_in_n};

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync_a <= 6'h00;
         sync_b <= 6'h00;
         prev_b <= 6'h00;
         warm   <= 3'h0;
      end
      else
      begin
         sync_a <= pins;
         sync_b <= sync_a;
         prev_b <= sync_b;
         // Edges valid once prev_b holds real pin data
         warm   <= {warm[1:0], 1'b1};
      end
   end

   logic enable_pin;
   logic clear_pin;
   logic inhibit_pin;
   logic devclr_pin;
   logic pulse_a;
   logic pulse_b;
   logic pulse_a_prev;
   logic pulse_b_prev;
   assign enable_pin   = sync_b[IN_ENABLE];
   assign clear_pin    = sync_b[IN_CLEAR];
   assign inhibit_pin  = sync_b[IN_INHIBIT];
   assign devclr_pin   = sync_b[IN_DEVCLR];
   assign pulse_a      = sync_b[4];
   assign pulse_b      = sync_b[5];
   assign pulse_a_prev = prev_b[4];
   assign pulse_b_prev = prev_b[5];

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers and APB slave
   logic [6:0]             config_reg;
   logic [SPEED_WIDTH-1:0] threshold;
   logic [6:0]             next_config_reg;
   logic [SPEED_WIDTH-1:0] next_threshold;
   logic                   wr_en;

   pulse_format_type fmt;
   assign fmt     = pulse_format_type'(config_reg[CFG_FMT_LSB +: 2]);
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;

   always_comb
   begin
      next_config_reg = config_reg;
      next_threshold  = threshold;
      if (wr_en && paddr == ADDR_CONFIG)
         next_config_reg = pwdata[6:0];
      if (wr_en && paddr == ADDR_THRESHOLD)
         next_threshold = pwdata[SPEED_WIDTH-1:0];
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         config_reg <= CFG_RESET;
         threshold  <= THRESHOLD_RESET[SPEED_WIDTH-1:0];
      end
      else
      begin
         config_reg <= next_config_reg;
         threshold  <= next_threshold;
      end
   end

   assign analog_unipolar = config_reg[CFG_RANGE];

   ////////////////////////////////////////////////////////////////////////////
   // Pulse decoder
   logic [POS_WIDTH-1:0] next_position;
   logic                 step;
   logic                 step_up;

   // Two-flop sync plus edge detect resolves 100 ns edges at 1 MHz
   always_comb
   begin
      step    = 1'b0;
      step_up = 1'b0;
      unique case (fmt)
         FMT_PULSE_DIR:
         begin
            step    = pulse_a && !pulse_a_prev;
            step_up = !pulse_b;
         end
         FMT_CCW_CW:
         begin
            step    = (pulse_a && !pulse_a_prev) ^ (pulse_b && !pulse_b_prev);
            step_up = pulse_a && !pulse_a_prev;
         end
         FMT_QUADRATURE:
         begin
            // Every edge of either phase; A leading counts up
            step    = (pulse_a ^ pulse_a_prev) ^ (pulse_b ^ pulse_b_prev);
            step_up = (pulse_a_prev ^ pulse_b) == 1'b0;
         end
         default:
         begin
            step    = 1'b0;
            step_up = 1'b0;
         end
      endcase
      // No false edge from pins already high at reset release
      if (!warm[2])
         step = 1'b0;
      if (config_reg[CFG_INVERT])
         step_up = !step_up;
      next_position = position_count;
      if (devclr_pin)
         next_position = '0;
      else if (step && !inhibit_pin)
         next_position = step_up ? position_count + 1'b1
                                 : position_count - 1'b1;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         position_count <= '0;
      else
         position_count <= next_position;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable and alarm handling
   logic [7:0] alarm_number;
   logic [7:0] next_alarm_number;
   logic       enable_req;
   logic       clear_edge;
   logic       clear_ok;

   assign enable_req = config_reg[CFG_INT_EN] ? 1'b1 : enable_pin;
   assign clear_edge = clear_pin && !prev_b[IN_CLEAR] && warm[2];
   assign clear_ok   = !enable_pin && clear_edge
                       && alarm_number <= ALARM_CLEARABLE_MAX;

   always_comb
   begin
      next_alarm_number = alarm_number;
      if (clear_ok)
         next_alarm_number = 8'h00;
      // A fault in the clearing cycle still latches
      if (alarm_event && alarm_code != 8'h00 && (alarm_number == 8'h00 || clear_ok))
         next_alarm_number = alarm_code;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         alarm_number <= 8'h00;
      else
         alarm_number <= next_alarm_number;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs
   logic next_servo_on;
   logic next_fault;
   logic next_ready;
   logic next_zero;
   logic next_index;
   logic alarm_active;

   assign alarm_active = alarm_number != 8'h00;

   always_comb
   begin
      next_servo_on = enable_req && !alarm_active;
      next_fault    = alarm_active ^ config_reg[CFG_FAULT_POL];
      next_ready    = next_servo_on;
      next_zero     = measured_speed < threshold;
      next_index    = config_reg[CFG_INDEX_SRC] ? aux_index_in
                                                : motor_index_in;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         servo_on        <= 1'b0;
         fault_out       <= 1'b0;
         drive_ready_out <= 1'b0;
         zero_speed_out  <= 1'b0;
         index_pulse_out <= 1'b0;
      end
      else
      begin
         servo_on        <= next_servo_on;
         fault_out       <= next_fault;
         drive_ready_out <= next_ready;
         zero_speed_out  <= next_zero;
         index_pulse_out <= next_index;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read mux with monitors
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        mapped;

   always_comb
   begin
      mapped       = 1'b1;
      next_prdata  = 32'h0000_0000;
      unique case (paddr)
         ADDR_CONFIG:    next_prdata[6:0] = config_reg;
         ADDR_THRESHOLD: next_prdata[SPEED_WIDTH-1:0] = threshold;
         ADDR_ALARM:     next_prdata[7:0] = alarm_number;
         ADDR_POSITION:  next_prdata[POS_WIDTH-1:0] = position_count;
         ADDR_IN_MON:    next_prdata[3:0] = sync_b[3:0];
         ADDR_OUT_MON:   next_prdata[3:0] = {index_pulse_out, zero_speed_out,
                                             drive_ready_out,
                                             alarm_active};
         default:        mapped = 1'b0;
      endcase
      next_pslverr = psel && !penable && !mapped;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

endmodule // spindle_command_io_logic

// *** bench/spindle_command_io_logic_checker.sv ***
// Port assertions for the spindle command and status logic
`timescale 1ns/10ps
module spindle_io_checker
   import spindle_io_pkg::*;
#(
   parameter int POS_WIDTH = 32
)(
   input wire logic                 clock,                // Clock
   input wire logic                 sys_rst,              // Reset
   input wire logic                 psel,                 // Select
   input wire logic                 penable,              // Enable
   input wire logic [7:0]           paddr,                // Address
   input wire logic                 pready,               // Ready
   input wire logic                 pslverr,              // Error
   input wire logic                 servo_on,             // Energized
   input wire logic                 drive_ready_out,      // Ready pin
   input wire logic                 alarm_event,          // Fault pulse
   input wire logic                 pulse_inhibit_in_n,   // Inhibit pin
   input wire logic                 deviation_clear_in_n, // Clear pin
   input wire logic [POS_WIDTH-1:0] position_count        // Count
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   bad_addr_a: assert property (psel && !penable && (paddr > ADDR_OUT_MON
      || paddr[1:0] != 2'h0) |=> pslverr) else $error("no error on unmapped address");
   good_addr_a: assert property (psel && !penable && paddr == ADDR_CONFIG |=> !pslverr)
      else $error("error on mapped address");
   ready_servo_a: assert property (drive_ready_out == servo_on)
      else $error("ready differs from servo state");
   alarm_off_a: assert property (alarm_event |-> ##[1:3] !servo_on)
      else $error("servo stays on after alarm");
   dev_clear_a: assert property ((!deviation_clear_in_n) [*4] |=> position_count == '0)
      else $error("count not cleared");
   inhibit_hold_a: assert property ((!pulse_inhibit_in_n && deviation_clear_in_n) [*4]
      |=> $stable(position_count)) else $error("count moved while inhibited");
   count_step_a: assert property (position_count == '0
      || position_count - $past(position_count) inside {'0, 1, '1})
      else $error("count jumped by more than one");
endmodule // spindle_io_checker

bind spindle_command_io_logic spindle_io_checker #(.POS_WIDTH(POS_WIDTH)) chk (
   .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .servo_on(servo_on), .drive_ready_out(drive_ready_out),
   .alarm_event(alarm_event), .pulse_inhibit_in_n(pulse_inhibit_in_n),
   .deviation_clear_in_n(deviation_clear_in_n), .position_count(position_count));

// *** bench/cnc_partner.sv ***
// Motion controller model driving command pulses and control pins
`timescale 1ns/10ps
module cnc_partner
   import spindle_io_pkg::*;
(
   input  wire logic clock, // Clock
   output logic      pulse, // Pulse / CCW / A
   output logic      sign,  // Dir / CW / B
   output logic      en_n,  // Enable pin
   output logic      clr_n, // Clear pin
   output logic      inh_n, // Inhibit pin
   output logic      dev_n  // Deviation clear pin
);
   logic [1:0] q = 2'h0;
   initial {pulse, sign, en_n, clr_n, inh_n, dev_n} = 6'h0F;
   // Half period keeps the rate below the 1 MHz ceiling
   task automatic hold();
      repeat (PULSE_PERIOD_CYCLES / 2) @(posedge clock);
   endtask
   // One count step in the chosen format
   task automatic step(input logic [1:0] fmt, input logic fwd);
      if (fmt == 2'h2)
      begin
         q = fwd ? q + 2'h1 : q - 2'h1;
         pulse <= q[1] ^ q[0];
         sign <= q[1];
      end
      else
      begin
         sign <= (fmt == 2'h0) ? !fwd : 1'b0;
         hold();
         if (fmt == 2'h1 && !fwd)
            sign <= 1'b1;
         else
            pulse <= 1'b1;
         hold();
         pulse <= 1'b0;
         if (fmt == 2'h1)
            sign <= 1'b0;
      end
      hold();
   endtask
endmodule // cnc_partner

// *** bench/spindle_command_io_logic_tb_top.sv ***
// Self-checking bench for the spindle command and status logic
`timescale 1ns/10ps
module spindle_command_io_logic_tb_top
   import spindle_io_pkg::*;
();
   logic        clock, sys_rst, psel, penable, pwrite, alarm_event, motor_index_in;
   logic        aux_index_in, pready, pslverr, servo_on, analog_unipolar, fault_out, err;
   logic        drive_ready_out, zero_speed_out, index_pulse_out, pulse, sign;
   logic        en_n, clr_n, inh_n, dev_n;
   logic [7:0]  paddr, alarm_code;
   logic [15:0] measured_speed;
   logic [31:0] pwdata, prdata, rd, position_count;
   int          miscompares = 0;
   int          checks_done = 0;

   cnc_partner p (.clock(clock), .pulse(pulse), .sign(sign), .en_n(en_n), .clr_n(clr_n),
      .inh_n(inh_n), .dev_n(dev_n));
   spindle_command_io_logic dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .command_pulse_in(pulse), .command_sign_in(sign),
      .drive_enable_in_n(en_n), .alarm_clear_in_n(clr_n), .pulse_inhibit_in_n(inh_n),
      .deviation_clear_in_n(dev_n), .measured_speed(measured_speed),
      .alarm_event(alarm_event), .alarm_code(alarm_code), .motor_index_in(motor_index_in),
      .aux_index_in(aux_index_in), .servo_on(servo_on), .analog_unipolar(analog_unipolar),
      .fault_out(fault_out), .drive_ready_out(drive_ready_out),
      .zero_speed_out(zero_speed_out), .index_pulse_out(index_pulse_out),
      .position_count(position_count));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check("register", exp, rd);
   endtask
   task automatic cfg(input logic [31:0] v);
      apb(1'b1, ADDR_CONFIG, v);
   endtask
   task automatic pin_pulse(input bit dev);
      if (dev) p.dev_n <= 1'b0; else p.clr_n <= 1'b0;
      cyc(5);
      if (dev) p.dev_n <= 1'b1; else p.clr_n <= 1'b1;
      cyc(5);
   endtask
   task automatic raise(input logic [7:0] c);
      alarm_event <= 1'b1;
      alarm_code <= c;
      @(posedge clock);
      alarm_event <= 1'b0;
      cyc(3);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      reg_chk(ADDR_CONFIG, 32'h0);
      reg_chk(ADDR_THRESHOLD, 32'(THRESHOLD_RESET));
      apb(1'b0, 8'h20, 32'h0);
      check("error", 32'h1, 32'(err));
   endtask
   task automatic t_pulses();
      for (int f = 0; f < 3; f++)
         for (int i = 0; i < 2; i++)
         begin
            cfg(32'(f + 4 * i));
            pin_pulse(1'b1);
            repeat (3) p.step(f[1:0], 1'b1);
            p.step(f[1:0], 1'b0);
            cyc(5);
            check("count", i ? 32'hFFFFFFFE : 32'h2, position_count);
         end
   endtask
   task automatic t_inhibit();
      p.inh_n <= 1'b0;
      pin_pulse(1'b1);
      check("count", 32'h0, position_count);
      repeat (2) p.step(2'h2, 1'b1);
      cyc(5);
      check("count", 32'h0, position_count);
      p.inh_n <= 1'b1;
      cfg(32'h3);
      p.step(2'h2, 1'b1);
      cyc(5);
      check("count", 32'h0, position_count);
   endtask
   task automatic t_enable();
      p.en_n <= 1'b0;
      cyc(5);
      check("servo", 32'h1, 32'(servo_on));
      check("ready", 32'h1, 32'(drive_ready_out));
      reg_chk(ADDR_IN_MON, 32'h1 << IN_ENABLE);
      p.en_n <= 1'b1;
      cfg(32'h1 << CFG_INT_EN);
      cyc(3);
      check("servo", 32'h1, 32'(servo_on));
      cfg(32'h0);
      cyc(3);
      check("servo", 32'h0, 32'(servo_on));
   endtask
   task automatic t_alarm();
      p.en_n <= 1'b0;
      cyc(5);
      raise(8'h05);
      check("fault", 32'h1, 32'(fault_out));
      check("servo", 32'h0, 32'(servo_on));
      reg_chk(ADDR_OUT_MON, 32'h1 << OUT_FAULT | 32'h1 << OUT_ZERO);
      pin_pulse(1'b0);
      reg_chk(ADDR_ALARM, 32'h5);
      p.en_n <= 1'b1;
      pin_pulse(1'b0);
      reg_chk(ADDR_ALARM, 32'h0);
      raise(8'h0C);
      pin_pulse(1'b0);
      reg_chk(ADDR_ALARM, 32'h0C);
      cfg(32'h1 << CFG_FAULT_POL);
      cyc(2);
      check("fault", 32'h0, 32'(fault_out));
      sys_rst <= 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      reg_chk(ADDR_ALARM, 32'h0);
   endtask
   task automatic t_misc();
      measured_speed <= 16'h0005;
      cyc(3);
      check("zero", 32'h1, 32'(zero_speed_out));
      measured_speed <= 16'h000A;
      motor_index_in <= 1'b1;
      cyc(3);
      check("zero", 32'h0, 32'(zero_speed_out));
      check("index", 32'h1, 32'(index_pulse_out));
      cfg(32'h1 << CFG_INDEX_SRC | 32'h1 << CFG_RANGE);
      cyc(2);
      check("index", 32'h0, 32'(index_pulse_out));
      check("range", 32'h1, 32'(analog_unipolar));
      aux_index_in <= 1'b1;
      cyc(2);
      check("index", 32'h1, 32'(index_pulse_out));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Whole run needs about 3200 cycles
   initial
   begin
      #200000;
      miscompares++;
      give_verdict();
   end
   initial
   begin
      {psel, penable, pwrite, alarm_event, motor_index_in, aux_index_in} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      alarm_code = 8'h00;
      measured_speed = 16'h0000;
      sys_rst = 1'b1;
      cyc(4);
      sys_rst <= 1'b0;
      t_regs();
      t_pulses();
      t_inhibit();
      t_enable();
      t_alarm();
      t_misc();
      give_verdict();
   end
endmodule // spindle_command_io_logic_tb_top
